/* File: hw/core_regs_pkg.sv */
// Package with offsets, field positions and reset values of the core special registers
package core_regs_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_STACK_LOW  = 8'h81;
   localparam logic [7:0] OFS_STACK_HIGH = 8'h9b;
   localparam logic [7:0] OFS_STATUS     = 8'hc5;
   localparam logic [7:0] OFS_FLAGS      = 8'hd0;
   localparam logic [7:0] OFS_MAIN       = 8'he0;
   localparam logic [7:0] OFS_AUX        = 8'hf0;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int FLG_CARRY   = 7;
   localparam int FLG_HALF    = 6;
   localparam int FLG_USER    = 5;
   localparam int FLG_BANK_HI = 4;
   localparam int FLG_BANK_LO = 3;
   localparam int FLG_WRAP    = 2;
   localparam int FLG_SPARE   = 1;
   localparam int FLG_PARITY  = 0;
   localparam int STS_HIGH    = 6;
   localparam int STS_LOW     = 5;
   // ---------------------------------------------------------------
   // Reset values and unmapped answer
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   // Stack operation codes
   typedef enum logic [1:0] {
      STK_NONE  = 2'b00,
      STK_STORE = 2'b01,
      STK_LOAD  = 2'b10
   } stack_op_e;
endpackage

/* File: hw/stack_addr_if.sv */
// Interface carrying stack address formation between core modules
`timescale 1ns/1ns
interface stack_addr_if;
   logic [7:0]  sp_low;     // Low stack byte
   logic [7:0]  sp_high;    // High stack byte
   logic        wide_mode;  // Wide address mode
   logic        is_store;   // Store needs pointer plus one
   logic [15:0] address;    // Formed address
   modport core (output sp_low, sp_high, wide_mode, is_store, input address);
   modport gen  (input sp_low, sp_high, wide_mode, is_store, output address);
endinterface

/* File: hw/stack_addr_gen.sv */
// Stack address generator for standard and wide stack modes
`timescale 1ns/1ns
module stack_addr_gen (
   // Address request
   stack_addr_if.gen      s
);
   import core_regs_pkg::*;
   logic [7:0] low_sel;   // Pointer byte, pre-incremented on a store only
   logic [7:0] high_sel;  // Upper address byte
   // Store uses pointer plus one, load uses pointer itself
   always_comb begin
      low_sel  = s.is_store ? 8'(s.sp_low + 8'h01) : s.sp_low;
      // Upper byte only meaningful in wide mode
      high_sel = s.wide_mode ? s.sp_high : 8'h00;
      s.address = {high_sel, low_sel};
   end
endmodule

/* File: hw/cpu_core_special_registers.sv */
// Core special registers: operand, flags, stack pointer and status
//
// Overview of operation
// - Main operand at e0, reset zero, bitwise
// - Auxiliary operand at f0, reset zero, bitwise
// - Flags carry, half carry, overflow, parity bits
// - Flags bits four, three select register bank
// - Bit five user flag, bit one spare
// - Store writes operand at pointer plus one
// - Load reads operand from pointer address
// - Wide mode: high byte extends stack pointer
// - Status read-only, bit six high priority active
// - Status bit five low priority active
// - Serial activity status bits read zero
// - Extended stack uses sixteen-bit data address
`timescale 1ns/1ns
module cpu_core_special_registers (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Bit access to operand registers
   input  wire logic        i_bit_wr,
   input  wire logic [7:0]  i_bit_addr,
   input  wire logic [2:0]  i_bit_sel,
   input  wire logic        i_bit_val,
   // Arithmetic flag updates from the execution unit
   input  wire logic        i_flag_wr,
   input  wire logic        i_carry_in,
   input  wire logic        i_half_in,
   input  wire logic        i_wrap_in,
   // Stack operations
   input  wire core_regs_pkg::stack_op_e i_stack_op,
   input  wire logic [7:0]  i_stack_rdata,
   input  wire logic        i_wide_mode,
   output logic      [15:0] o_stack_addr,
   output logic      [7:0]  o_stack_wdata,
   output logic             o_stack_we,
   // Interrupt service state
   input  wire logic        i_high_prio_active,
   input  wire logic        i_low_prio_active,
   // Core state seen by the rest of the CPU
   output logic      [7:0]  o_main_operand,
   output logic      [7:0]  o_aux_operand,
   output logic      [1:0]  o_bank_select,
   output logic             o_carry
);
   import core_regs_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  main_operand;   // Main operand register
      logic [7:0]  aux_operand;    // Auxiliary operand register
      logic [7:0]  flags;          // Program flags word
      logic [7:0]  sp_low;         // Stack pointer low
      logic [7:0]  sp_high;        // Stack pointer high
      logic [7:0]  status;         // Captured status byte
      logic [7:0]  rdata;          // Read data, one cycle after strobe
      logic [15:0] stack_addr;     // Stack memory address
      logic [7:0]  stack_wdata;    // Stack memory write data
      logic        stack_we;       // Stack memory write pulse
      logic        load_pend;      // Load waiting for memory data
   } core_s;

   core_s state_reg;   // Registered state
   core_s state_next;  // Next state

   stack_addr_if sa ();  // Address generator link
   logic [7:0]   flags_w;  // Flags after writes, before parity
   logic [7:0]   main_w;   // Operand after writes and loads

   // ---------------------------------------------------------------
   // Stack address formation
   // ---------------------------------------------------------------
   assign sa.sp_low    = state_reg.sp_low;
   assign sa.sp_high   = state_reg.sp_high;
   assign sa.wide_mode = i_wide_mode;
   assign sa.is_store  = (i_stack_op == STK_STORE);

   stack_addr_gen u_stack_addr_gen (
      .s (sa.gen)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Writes, bit access, stack moves and hardware flag updates
   always_comb begin
      state_next          = state_reg;
      state_next.stack_we = 1'b0;
      // Byte writes over the register port
      if (i_wr) begin
         unique case (i_addr)
            OFS_MAIN:       state_next.main_operand = i_wdata;
            OFS_AUX:        state_next.aux_operand  = i_wdata;
            OFS_FLAGS:      state_next.flags        = i_wdata;
            OFS_STACK_LOW:  state_next.sp_low       = i_wdata;
            OFS_STACK_HIGH: state_next.sp_high      = i_wdata;
            // Status and unmapped offsets ignore writes
            default: ;
         endcase
      end
      // Single-bit writes; operand registers are bit addressable
      if (i_bit_wr) begin
         if (i_bit_addr == OFS_MAIN) begin
            state_next.main_operand[i_bit_sel] = i_bit_val;
         end else if (i_bit_addr == OFS_AUX) begin
            state_next.aux_operand[i_bit_sel] = i_bit_val;
         end else if (i_bit_addr == OFS_FLAGS) begin
            state_next.flags[i_bit_sel] = i_bit_val;
         end
      end
      // Execution unit flag updates take priority over software writes
      if (i_flag_wr) begin
         state_next.flags[FLG_CARRY] = i_carry_in;
         state_next.flags[FLG_HALF]  = i_half_in;
         state_next.flags[FLG_WRAP]  = i_wrap_in;
      end
      // Stack store: pointer pre-increments, operand goes out
      if (i_stack_op == STK_STORE) begin
         state_next.stack_addr  = sa.address;
         state_next.stack_wdata = state_reg.main_operand;
         state_next.stack_we    = 1'b1;
         state_next.sp_low      = 8'(state_reg.sp_low + 8'h01);
         state_next.load_pend   = 1'b0;
      end else if (i_stack_op == STK_LOAD) begin
         // Stack load: address is the pointer, data returns next cycle
         state_next.stack_addr = sa.address;
         state_next.sp_low     = 8'(state_reg.sp_low - 8'h01);
         state_next.load_pend  = 1'b1;
      end else begin
         state_next.load_pend = 1'b0;
      end
      // Memory data lands in the main operand
      if (state_reg.load_pend) begin
         state_next.main_operand = i_stack_rdata;
      end
      main_w  = state_next.main_operand;
      flags_w = state_next.flags;
      // Parity follows the operand every cycle, so software cannot break it
      flags_w[FLG_PARITY] = ^main_w;
      state_next.flags    = flags_w;
      // Status: only interrupt bits live, serial bits fixed at zero
      state_next.status = RST_BYTE;
      state_next.status[STS_HIGH] = i_high_prio_active;
      state_next.status[STS_LOW]  = i_low_prio_active;
      // Read data presented one cycle after the strobe
      state_next.rdata = UNMAPPED_RD;
      if (i_rd) begin
         unique case (i_addr)
            OFS_MAIN:       state_next.rdata = state_reg.main_operand;
            OFS_AUX:        state_next.rdata = state_reg.aux_operand;
            OFS_FLAGS:      state_next.rdata = state_reg.flags;
            OFS_STACK_LOW:  state_next.rdata = state_reg.sp_low;
            OFS_STACK_HIGH: state_next.rdata = state_reg.sp_high;
            OFS_STATUS:     state_next.rdata = state_reg.status;
            default:        state_next.rdata = UNMAPPED_RD;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Synchronous active-low reset, all registers clear to zero
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs straight from flip-flops
   // ---------------------------------------------------------------
   assign o_rdata        = state_reg.rdata;
   assign o_stack_addr   = state_reg.stack_addr;
   assign o_stack_wdata  = state_reg.stack_wdata;
   assign o_stack_we     = state_reg.stack_we;
   assign o_main_operand = state_reg.main_operand;
   assign o_aux_operand  = state_reg.aux_operand;
   assign o_bank_select  = state_reg.flags[FLG_BANK_HI:FLG_BANK_LO];
   assign o_carry        = state_reg.flags[FLG_CARRY];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_store_req;
      i_stack_op == STK_STORE && !i_wide_mode;
   endsequence

   property p_parity;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg.flags[FLG_PARITY] == ^state_reg.main_operand;
   endproperty
   a_parity: assert property (p_parity) else $error("parity wrong");

   property p_main_wr;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr && i_addr == OFS_MAIN && !i_bit_wr && i_stack_op == STK_NONE
       && !state_reg.load_pend) |=> o_main_operand == $past(i_wdata);
   endproperty
   a_main_wr: assert property (p_main_wr) else $error("main write lost");

   property p_aux_wr;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr && i_addr == OFS_AUX && !i_bit_wr) |=> o_aux_operand == $past(i_wdata);
   endproperty
   a_aux_wr: assert property (p_aux_wr) else $error("aux write lost");

   property p_bank;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr && i_addr == OFS_FLAGS && !i_bit_wr) |=> o_bank_select == $past(i_wdata[4:3]);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");

   property p_store;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_store_req |=> o_stack_we && o_stack_addr == {8'h00, 8'($past(state_reg.sp_low) + 8'h01)}
                     && o_stack_wdata == $past(o_main_operand);
   endproperty
   a_store: assert property (p_store) else $error("store address wrong");

   property p_load;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_stack_op == STK_LOAD && !i_wr && !i_bit_wr) ##1 (i_stack_op == STK_NONE && !i_wr && !i_bit_wr)
      |=> o_main_operand == $past(i_stack_rdata);
   endproperty
   a_load: assert property (p_load) else $error("load data wrong");

   property p_wide;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_stack_op == STK_LOAD && i_wide_mode)
      |=> o_stack_addr == {$past(state_reg.sp_high), $past(state_reg.sp_low)};
   endproperty
   a_wide: assert property (p_wide) else $error("wide address wrong");

   property p_status;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_rd && i_addr == OFS_STATUS) |=> o_rdata == {1'b0, $past(state_reg.status[6:5]), 5'h00};
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

   property p_low_prio;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_low_prio_active ##1 (i_rd && i_addr == OFS_STATUS) |=> o_rdata[STS_LOW];
   endproperty
   a_low_prio: assert property (p_low_prio) else $error("low prio bit wrong");

   property p_serial_zero;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      state_reg.status[4:0] == 5'h00 && !state_reg.status[7];
   endproperty
   a_serial_zero: assert property (p_serial_zero) else $error("serial bits set");

   // High priority level must show in the status read one cycle on
   property p_high_prio;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_high_prio_active ##1 (i_rd && i_addr == OFS_STATUS) |=> o_rdata[STS_HIGH];
   endproperty
   a_high_prio: assert property (p_high_prio) else $error("high prio bit wrong");

   // Read data bus idles at zero, so a stale byte is never mistaken for data
   property p_rd_idle;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

   // Every store raises the write pulse exactly once
   property p_store_we;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_stack_op == STK_STORE |=> o_stack_we;
   endproperty
   a_store_we: assert property (p_store_we) else $error("store pulse missing");

   // No write pulse without a store, so loads never corrupt memory
   property p_no_we;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_stack_op != STK_STORE |=> !o_stack_we;
   endproperty
   a_no_we: assert property (p_no_we) else $error("stray store pulse");

   // Store leaves the pointer on the byte just written
   property p_sp_inc;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_stack_op == STK_STORE && !(i_wr && i_addr == OFS_STACK_LOW))
      |=> state_reg.sp_low == 8'($past(state_reg.sp_low) + 8'h01);
   endproperty
   a_sp_inc: assert property (p_sp_inc) else $error("store pointer wrong");

   // Load steps the pointer back by one
   property p_sp_dec;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_stack_op == STK_LOAD && !(i_wr && i_addr == OFS_STACK_LOW))
      |=> state_reg.sp_low == 8'($past(state_reg.sp_low) - 8'h01);
   endproperty
   a_sp_dec: assert property (p_sp_dec) else $error("load pointer wrong");

   // Wide store uses the high byte above the incremented pointer
   property p_wide_store;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_stack_op == STK_STORE && i_wide_mode)
      |=> o_stack_addr == {$past(state_reg.sp_high), 8'($past(state_reg.sp_low) + 8'h01)};
   endproperty
   a_wide_store: assert property (p_wide_store) else $error("wide store wrong");

   // Outside wide mode the stack stays in the low 256 bytes
   property p_narrow_load;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_stack_op == STK_LOAD && !i_wide_mode) |=> o_stack_addr[15:8] == 8'h00;
   endproperty
   a_narrow_load: assert property (p_narrow_load) else $error("narrow load wrong");

   // Execution unit flags land one cycle after the update strobe
   property p_flag_upd;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_flag_wr |=> o_carry == $past(i_carry_in)
                    && state_reg.flags[FLG_HALF] == $past(i_half_in)
                    && state_reg.flags[FLG_WRAP] == $past(i_wrap_in);
   endproperty
   a_flag_upd: assert property (p_flag_upd) else $error("flag update lost");

   // User and spare bits keep what software wrote
   property p_user_bits;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_wr && i_addr == OFS_FLAGS && !i_bit_wr)
      |=> state_reg.flags[FLG_USER] == $past(i_wdata[FLG_USER])
          && state_reg.flags[FLG_SPARE] == $past(i_wdata[FLG_SPARE]);
   endproperty
   a_user_bits: assert property (p_user_bits) else $error("user bits lost");

   // Single-bit write into the auxiliary operand
   property p_aux_bit;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_bit_wr && i_bit_addr == OFS_AUX && !i_wr)
      |=> o_aux_operand[$past(i_bit_sel)] == $past(i_bit_val);
   endproperty
   a_aux_bit: assert property (p_aux_bit) else $error("aux bit write lost");

   // Single-bit write into the main operand; pending load data would win
   property p_main_bit;
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_bit_wr && i_bit_addr == OFS_MAIN && !i_wr && !state_reg.load_pend)
      |=> o_main_operand[$past(i_bit_sel)] == $past(i_bit_val);
   endproperty
   a_main_bit: assert property (p_main_bit) else $error("main bit write lost");
endmodule

/* File: verif/cpu_core_special_registers_tb.sv */
// Self-checking testbench for the core special registers
`timescale 1ns/1ns
module cpu_core_special_registers_tb;
   import core_regs_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus, observed outputs and bench state
   // ---------------------------------------------------------------
   logic        i_clk_sys, i_rst_n, i_wr, i_rd, i_bit_wr, i_bit_val, i_flag_wr;
   logic [7:0]  i_addr, i_wdata, i_bit_addr, i_stack_rdata;
   logic [2:0]  i_bit_sel;
   logic        i_carry_in, i_half_in, i_wrap_in, i_wide_mode;
   logic        i_high_prio_active, i_low_prio_active;
   stack_op_e   i_stack_op;
   logic [7:0]  o_rdata, o_stack_wdata, o_main_operand, o_aux_operand;
   logic [15:0] o_stack_addr;
   logic        o_stack_we, o_carry;
   logic [1:0]  o_bank_select;
   int          err_total = 0;
   int          n_checks = 0;
   // Offsets in model order; the last one is unmapped
   logic [7:0]  amap [7] = '{OFS_MAIN, OFS_AUX, OFS_FLAGS, OFS_STACK_LOW,
                             OFS_STACK_HIGH, OFS_STATUS, 8'h80};
   logic [7:0]  mdl  [7];  // Expected contents, same order as amap

   cpu_core_special_registers dut_u (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bit_wr(i_bit_wr),
      .i_bit_addr(i_bit_addr), .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val),
      .i_flag_wr(i_flag_wr), .i_carry_in(i_carry_in), .i_half_in(i_half_in),
      .i_wrap_in(i_wrap_in), .i_stack_op(i_stack_op), .i_stack_rdata(i_stack_rdata),
      .i_wide_mode(i_wide_mode), .o_stack_addr(o_stack_addr),
      .o_stack_wdata(o_stack_wdata), .o_stack_we(o_stack_we),
      .i_high_prio_active(i_high_prio_active), .i_low_prio_active(i_low_prio_active),
      .o_main_operand(o_main_operand), .o_aux_operand(o_aux_operand),
      .o_bank_select(o_bank_select), .o_carry(o_carry));

   // ---------------------------------------------------------------
   // Clock, helpers and closing
   // ---------------------------------------------------------------
   // 125 MHz system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   // Parity is never stored: it always mirrors the operand's ones count
   function automatic logic [7:0] exp_rd(int k);
      if (k == 2) return {mdl[2][7:1], ^mdl[0]};
      return mdl[k];
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One-cycle write; the idle cycle before it keeps strobes from colliding
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   // Read table entry k; data stand only in the cycle after the strobe
   task automatic rd_chk(input int k);
      @(posedge i_clk_sys);
      i_addr <= amap[k];
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk("rdata", 16'(o_rdata), 16'(exp_rd(k)));
   endtask

   task automatic check_all();
      for (int k = 0; k < 7; k++) rd_chk(k);
   endtask

   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      repeat (6000) @(posedge i_clk_sys);
      err_total++;
      wrap_up();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] d, ptr, ext, hi, r;
      logic [2:0] f;
      int         k;
      {i_rst_n, i_wr, i_rd, i_bit_wr, i_bit_val, i_flag_wr} = '0;
      {i_addr, i_wdata, i_bit_addr, i_bit_sel} = '0;
      {i_carry_in, i_half_in, i_wrap_in, i_wide_mode} = '0;
      {i_high_prio_active, i_low_prio_active} = '0;
      i_stack_op = STK_NONE;
      i_stack_rdata = 8'h5a;
      void'($urandom(14));
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      mdl = '{default: 8'h00};
      check_all();
      // Random writes, each followed by a read back and the parity view
      repeat (40) begin
         k = $urandom_range(0, 6);
         d = 8'($urandom);
         wr(amap[k], d);
         if (k < 5) mdl[k] = d;
         rd_chk(k);
         rd_chk(2);
         chk("bank", 16'(o_bank_select), 16'(mdl[2][4:3]));
         chk("main", 16'(o_main_operand), 16'(mdl[0]));
         chk("aux", 16'(o_aux_operand), 16'(mdl[1]));
         chk("carry", 16'(o_carry), 16'(mdl[2][7]));
      end
      // Every bit of the three bit-accessible registers
      for (int m = 0; m < 3; m++) begin
         for (int j = 0; j < 8; j++) begin
            d[0] = 1'($urandom);
            @(posedge i_clk_sys);
            i_bit_addr <= amap[m];
            i_bit_sel <= 3'(j);
            i_bit_val <= d[0];
            i_bit_wr <= 1'b1;
            @(posedge i_clk_sys);
            i_bit_wr <= 1'b0;
            mdl[m][j] = d[0];
         end
         rd_chk(m);
      end
      // Flag update from execution wins over a software write in the same cycle
      repeat (8) begin
         d = 8'($urandom);
         f = 3'($urandom);
         @(posedge i_clk_sys);
         {i_carry_in, i_half_in, i_wrap_in} <= f;
         i_flag_wr <= 1'b1;
         i_addr <= OFS_FLAGS;
         i_wdata <= d;
         i_wr <= 1'b1;
         @(posedge i_clk_sys);
         i_flag_wr <= 1'b0;
         i_wr <= 1'b0;
         mdl[2] = {f[2], f[1], d[5:3], f[0], d[1:0]};
         rd_chk(2);
      end
      // Interrupt service levels show in status; writes there are ignored
      for (int j = 0; j < 4; j++) begin
         @(posedge i_clk_sys);
         i_high_prio_active <= j[1];
         i_low_prio_active <= j[0];
         mdl[5] = {1'b0, j[1], j[0], 5'h00};
         wr(OFS_STATUS, 8'hff);
         rd_chk(5);
      end
      // Store immediately followed by load, both address modes
      for (int j = 0; j < 8; j++) begin
         ptr = (j == 0) ? 8'hff : 8'($urandom_range(0, 254));
         ext = 8'($urandom);
         d = 8'($urandom);
         r = 8'($urandom);
         i_wide_mode <= j[0];
         wr(OFS_STACK_LOW, ptr);
         wr(OFS_STACK_HIGH, ext);
         wr(OFS_MAIN, d);
         hi = j[0] ? ext : 8'h00;
         @(posedge i_clk_sys);
         i_stack_op <= STK_STORE;
         @(posedge i_clk_sys);
         i_stack_op <= STK_LOAD;
         #1;
         chk("st_we", 16'(o_stack_we), 16'h0001);
         chk("st_addr", o_stack_addr, {hi, ptr + 8'h01});
         chk("st_data", 16'(o_stack_wdata), 16'(d));
         @(posedge i_clk_sys);
         i_stack_op <= STK_NONE;
         i_stack_rdata <= r;
         #1;
         chk("ld_addr", o_stack_addr, {hi, ptr + 8'h01});
         chk("ld_we", 16'(o_stack_we), 16'h0000);
         @(posedge i_clk_sys);
         i_stack_rdata <= ~r;
         #1;
         chk("ld_main", 16'(o_main_operand), 16'(r));
         mdl[0] = r;
         mdl[3] = ptr;
         mdl[4] = ext;
         rd_chk(3);
      end
      // Reset again in mid-run: everything returns to zero
      @(posedge i_clk_sys);
      i_rst_n <= 1'b0;
      i_high_prio_active <= 1'b0;
      i_low_prio_active <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      mdl = '{default: 8'h00};
      check_all();
      wrap_up();
   end
endmodule
